// ### src/sld_scan_driver.sv
// Purpose: Serial command port feeding a four digit multiplexed LED driver
// Assumes: clk at 10 MHz, pins asynchronous to clk, sys_rst synchronous
// Notes: Pins are resynchronised, so a shift clock must stay well below clk
//
// Contract
// - Each rising shift clock edge shifts serial data into the register.
// - Load rising edge latches the upper byte as register selection.
// - Load falling edge writes the lower byte into the selected register.
// - A serial output passes shifted data on for chaining.
// - Eight segment outputs: seven segments plus decimal point.
// - Four digit outputs, one at a time, scanned in turn.
// - Decoding maps codes to numerals, some letters and blank.
// - Four digits with points, or thirty-two raw LEDs without decoding.
// - Every control action needs a complete sixteen bit command; the code acts on any load fall, whatever number of bits was shifted.
// - Words travel most significant bit first.
// - Top address nibble picks blank, normal, load, all on, standby.
// - Intensity sets digit duty from zero to fifteen sixteenths.
`timescale 1ns/1ps
`default_nettype none
module sld_scan_driver #(
  parameter int STEP_CYCLES = sld_pkg::STEP_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serial_data_in,
  input wire logic shift_clock,
  input wire logic load_strobe,
  output logic serial_data_out,
  output logic [7:0] segment_outputs,
  output logic [3:0] digit_select_outputs
);

  typedef struct packed {
    logic [2:0] din_s;
    logic [2:0] ck_s;
    logic [2:0] ld_s;
    logic ck_f;
    logic ld_f;
    logic [15:0] sh;
    logic [7:0] sel;
    logic [3:0] mode;
    logic [3:0] duty;
    logic dec_en;
    logic [1:0] last_dig;
    logic [31:0] data;
    logic [7:0] pre;
    logic [3:0] step;
    logic [1:0] dig;
    logic [7:0] seg;
    logic [3:0] dsel;
    logic sout;
  } sld_state_t;

  sld_state_t q;
  sld_state_t d;
  logic ck_rise;
  logic ld_rise;
  logic ld_fall;
  logic [7:0] cur_data;

  // Code to segment pattern; codes A to E give letters, F is blank
  function automatic logic [6:0] sld_decode(input logic [3:0] code);
    case (code)
      4'h0: sld_decode = sld_pkg::SEG_ZERO;
      4'h1: sld_decode = 7'h06;
      4'h2: sld_decode = 7'h5B;
      4'h3: sld_decode = 7'h4F;
      4'h4: sld_decode = 7'h66;
      4'h5: sld_decode = 7'h6D;
      4'h6: sld_decode = 7'h7D;
      4'h7: sld_decode = 7'h07;
      4'h8: sld_decode = 7'h7F;
      4'h9: sld_decode = 7'h6F;
      4'hA: sld_decode = 7'h77;
      4'hB: sld_decode = 7'h7C;
      4'hC: sld_decode = 7'h39;
      4'hD: sld_decode = 7'h5E;
      4'hE: sld_decode = 7'h79;
      default: sld_decode = sld_pkg::SEG_BLANK;
    endcase
  endfunction : sld_decode

  ////////////////////////////////////////////////////////////////////////////
  // Edge finding: an edge counts once the second and third stages agree
  assign ck_rise = (q.ck_s[1] == q.ck_s[2]) && q.ck_s[2] && !q.ck_f;
  assign ld_rise = (q.ld_s[1] == q.ld_s[2]) && q.ld_s[2] && !q.ld_f;
  assign ld_fall = (q.ld_s[1] == q.ld_s[2]) && !q.ld_s[2] && q.ld_f;
  assign cur_data = q.data[8*q.dig +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d = q;
    d.din_s = {q.din_s[1:0], serial_data_in};
    d.ck_s = {q.ck_s[1:0], shift_clock};
    d.ld_s = {q.ld_s[1:0], load_strobe};
    if (q.ck_s[1] == q.ck_s[2])
    begin
      d.ck_f = q.ck_s[2];
    end
    if (q.ld_s[1] == q.ld_s[2])
    begin
      d.ld_f = q.ld_s[2];
    end
    // Data stage is delayed like the clock stage, so setup is kept
    if (ck_rise)
    begin
      d.sh = {q.sh[14:0], q.din_s[2]};
    end
    // Top stage feeds the chain output
    d.sout = q.sh[15];
    // Address byte latched on rise, held until the falling write
    if (ld_rise)
    begin
      d.sel = q.sh[15:8];
    end
    // Only the load fall changes any setting, whatever number of bits was shifted
    if (ld_fall)
    begin
      case (q.sel[7:4])
        sld_pkg::MODE_BLANK, sld_pkg::MODE_NORMAL, sld_pkg::MODE_ALLON:
          d.mode = q.sel[7:4];
        sld_pkg::MODE_STANDBY:
        begin
          d.mode = sld_pkg::MODE_STANDBY;
          // Clear re-initialises data, keeping the blank display
          if (q.sh[3:0] == sld_pkg::STBY_CLEAR)
          begin
            d.mode = sld_pkg::RST_MODE;
            d.data = '0;
            d.duty = sld_pkg::RST_DUTY;
            d.dec_en = sld_pkg::RST_DECODE;
            d.last_dig = sld_pkg::RST_LAST_DIGIT;
          end
        end
        sld_pkg::MODE_LOAD:
        begin
          if (q.sel[3:0] == sld_pkg::REG_DUTY)
          begin
            d.duty = q.sh[3:0];
          end
          else if (q.sel[3:0] == sld_pkg::REG_DECDIG)
          begin
            d.dec_en = q.sh[4];
            d.last_dig = q.sh[1:0];
          end
          else if (q.sel[3:0] >= sld_pkg::REG_DATA0 &&
                   q.sel[3:0] <= sld_pkg::REG_DATA3)
          begin
            d.data[8*(q.sel[1:0] - 2'h2) +: 8] = q.sh[7:0];
          end
        end
        default:
          d.mode = q.mode;
      endcase
    end
    // Scan timing: sixteen duty steps per digit slot
    d.pre = q.pre + 8'h01;
    if (q.pre == 8'(STEP_CYCLES - 1))
    begin
      d.pre = 8'h00;
      d.step = q.step + 4'h1;
      if (q.step == 4'hF)
      begin
        d.dig = (q.dig >= q.last_dig) ? 2'h0 : q.dig + 2'h1;
      end
    end
    // Outputs; raw data lights thirty-two LEDs when decoding is off
    d.dsel = (q.step < q.duty) ? (4'h1 << q.dig) : 4'h0;
    if (q.dec_en)
    begin
      d.seg = {cur_data[7], sld_decode(cur_data[3:0])};
    end
    else
    begin
      d.seg = cur_data;
    end
    if (q.mode == sld_pkg::MODE_ALLON)
    begin
      d.seg = 8'hFF;
    end
    else if (q.mode != sld_pkg::MODE_NORMAL)
    begin
      // Blank and standby keep the data but light nothing
      d.seg = 8'h00;
      d.dsel = 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.mode <= sld_pkg::RST_MODE;
      q.duty <= sld_pkg::RST_DUTY;
      q.dec_en <= sld_pkg::RST_DECODE;
      q.last_dig <= sld_pkg::RST_LAST_DIGIT;
    end
    else
    begin
      q <= d;
    end
  end

  assign serial_data_out = q.sout;
  assign segment_outputs = q.seg;
  assign digit_select_outputs = q.dsel;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  shift_adv_a: assert property (ck_rise |=> q.sh ==
    {$past(q.sh[14:0]), $past(q.din_s[2])})
    else $error("shift register did not advance");
  chain_out_a: assert property (ck_rise |->
    ##2 serial_data_out == $past(q.sh[14], 2))
    else $error("chain output not top stage");
  sel_latch_a: assert property (ld_rise |=> q.sel == $past(q.sh[15:8]))
    else $error("selection not latched");
  sel_hold_a: assert property (q.ld_f && ck_rise |=> $stable(q.sel))
    else $error("selection moved while load high");
  duty_write_a: assert property (ld_fall &&
    q.sel == {sld_pkg::MODE_LOAD, sld_pkg::REG_DUTY} |=>
    q.duty == $past(q.sh[3:0]))
    else $error("duty write lost");
  blank_off_a: assert property (q.mode == sld_pkg::MODE_BLANK |=>
    segment_outputs == 8'h00 && digit_select_outputs == 4'h0)
    else $error("blank mode lit outputs");
  all_on_a: assert property (q.mode == sld_pkg::MODE_ALLON |=>
    segment_outputs == 8'hFF)
    else $error("all on mode not lit");
  one_digit_a: assert property ($onehot0(digit_select_outputs))
    else $error("more than one digit on");
  zero_duty_a: assert property (q.duty == 4'h0 |=>
    digit_select_outputs == 4'h0)
    else $error("digit on at zero duty");
  decode_zero_a: assert property (q.mode == sld_pkg::MODE_NORMAL &&
    q.dec_en && cur_data[3:0] == 4'h0 |=>
    segment_outputs[6:0] == sld_pkg::SEG_ZERO)
    else $error("code zero not decoded");

  load_fall_c: cover property (ld_fall);
  normal_lit_c: cover property (q.mode == sld_pkg::MODE_NORMAL &&
    digit_select_outputs != 4'h0);
  raw_mode_c: cover property (!q.dec_en && segment_outputs != 8'h00);
  standby_c: cover property (q.mode == sld_pkg::MODE_STANDBY);

endmodule : sld_scan_driver
`default_nettype wire

// ### include/sld_pkg.sv
// Purpose: Constants for the serial LED segment scan driver
// Assumes: 16-bit command word, address byte on top, data byte below
// Notes: Segment bit 0 is segment a, bit 6 is g, bit 7 the decimal point
package sld_pkg;
  // Command word layout
  localparam int WORD_BITS = 16;
  localparam int ADDR_LSB = 8;
  localparam int MODE_LSB = 4;
  // Operating modes, top nibble of the address byte
  localparam logic [3:0] MODE_BLANK = 4'h0;
  localparam logic [3:0] MODE_NORMAL = 4'h1;
  localparam logic [3:0] MODE_LOAD = 4'h2;
  localparam logic [3:0] MODE_ALLON = 4'h3;
  localparam logic [3:0] MODE_STANDBY = 4'h4;
  // Register selects in load register mode, low nibble of the address
  localparam logic [3:0] REG_DUTY = 4'h0;
  localparam logic [3:0] REG_DECDIG = 4'h1;
  localparam logic [3:0] REG_DATA0 = 4'h2;
  localparam logic [3:0] REG_DATA3 = 4'h5;
  // Standby data nibble that requests a clear instead of standby
  localparam logic [3:0] STBY_CLEAR = 4'h1;
  // Reset values
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic [3:0] RST_DUTY = 4'hF;
  localparam logic [1:0] RST_LAST_DIGIT = 2'h3;
  localparam logic RST_DECODE = 1'b1;
  // Timing: clock cycles per duty step
  localparam int STEP_CYCLES = 16;
  // Decoded patterns
  localparam logic [6:0] SEG_ZERO = 7'h3F;
  localparam logic [6:0] SEG_BLANK = 7'h00;
endpackage : sld_pkg

// ### bench/sld_host_model.sv
// Purpose: Host side of the three-wire command port
// Assumes: clk at 100 ns, shift clock period 800 ns
// Notes: Pins change only on clk rising edges
`timescale 1ns/1ps
`default_nettype none
module sld_host_model (
  input wire logic clk,
  output logic shift_clock,
  output logic serial_data_in,
  output logic load_strobe
);
  // Shift clock idles low between frames
  initial
  begin
    shift_clock = 1'b0;
    serial_data_in = 1'b0;
    load_strobe = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge clk);
  endtask : half
  // Data set at the low phase, so it is steady 400 ns around each rise
  task automatic put_bit(input logic b);
    half();
    shift_clock <= 1'b0;
    serial_data_in <= b;
    half();
    shift_clock <= 1'b1;
  endtask : put_bit
  // Whole word, then a load pulse; extra bits may shift while it is high
  task automatic send(input logic [15:0] w, input int extra,
                      input logic [7:0] x);
    for (int i = 15; i >= 0; i--) put_bit(w[i]);
    half();
    shift_clock <= 1'b0;
    serial_data_in <= ~w[0]; // Released line shows the inverse
    half();
    load_strobe <= 1'b1;
    for (int i = extra - 1; i >= 0; i--) put_bit(x[i]);
    half();
    shift_clock <= 1'b0;
    load_strobe <= 1'b0;
    half();
  endtask : send
endmodule : sld_host_model
`default_nettype wire

// ### bench/tb_serial_led_segment_scan_driver.sv
// Purpose: Self-checking bench for the segment scan driver
// Assumes: STEP_CYCLES 2, so a scan of four digits lasts 128 clk
// Notes: 256-cycle windows hold eight whole digit slots for any digit count
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_serial_led_segment_scan_driver;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  wire logic sck, sdi, ld;
  logic sdo;
  logic [7:0] seg;
  logic [3:0] dig;
  int bad_count = 0;
  int cmp_count = 0;
  int mode = 0;
  int duty = 15;
  logic dec = 1'b1;
  logic [1:0] last = 2'h3;
  logic [15:0] sh;
  logic [7:0] dat [4] = '{default: 8'h00};
  logic [15:0] seq [7] = '{16'h0000, 16'h3000, 16'h4000, 16'h1000,
                           16'h5000, 16'h4001, 16'h1000};
  always #50 clk = ~clk;
  sld_scan_driver #(.STEP_CYCLES(2)) sld_scan_driver_i (.clk(clk),
    .sys_rst(sys_rst), .serial_data_in(sdi), .shift_clock(sck),
    .load_strobe(ld), .serial_data_out(sdo), .segment_outputs(seg),
    .digit_select_outputs(dig));
  sld_host_model sld_host_model_i (.clk(clk), .shift_clock(sck),
    .serial_data_in(sdi), .load_strobe(ld));
  // Reference pattern of digit n; letters are never stored while decoding
  function automatic logic [7:0] expect_seg(input int n);
    logic [6:0] t [10];
    t = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
    if (mode == 3) return 8'hFF;
    if (!dec) return dat[n];
    if (dat[n][3:0] == 4'hF) return {dat[n][7], 7'h00};
    return {dat[n][7], t[dat[n][3:0]]};
  endfunction : expect_seg
  // Send a word, check the chain output, then update the model
  task automatic cmd(input logic [15:0] w, input int extra = 0,
                     input logic [7:0] x = 8'h00);
    sld_host_model_i.send(w, extra, x);
    sh = w;
    for (int i = extra - 1; i >= 0; i--) sh = {sh[14:0], x[i]};
    repeat (40) @(posedge clk);
    `CHK("serial_data_out", sh[15], sdo)
    case (w[15:12])
      4'h0: mode = 0;
      4'h1: mode = 1;
      4'h2:
        if (w[11:8] == 4'h0) duty = sh[3:0];
        else if (w[11:8] == 4'h1) {dec, last} = {sh[4], sh[1:0]};
        else if (w[11:8] < 4'h6) dat[w[11:8] - 4'h2] = sh[7:0];
      4'h3: mode = 3;
      4'h4:
        if (sh[3:0] == 4'h1)
        begin
          {mode, duty, dec, last} = {32'd0, 32'd15, 1'b1, 2'h3};
          dat = '{default: 8'h00};
        end
        else mode = 4;
      default: ;
    endcase
  endtask : cmd
  // Watch 256 cycles: one digit at a time, right pattern, right duty
  task automatic observe();
    int on, n;
    on = 0;
    repeat (256)
    begin
      @(negedge clk);
      if (dig !== 4'h0)
      begin
        on++;
        n = $clog2(dig);
        `CHK("digit one-hot", 1'b1, $onehot(dig))
        `CHK("digit in range", 1'b1, n <= last)
        `CHK("segments", expect_seg(n), seg)
      end
    end
    `CHK("lit cycles", (mode == 1 || mode == 3) ? 16 * duty : 0, on)
  endtask : observe
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // Main sequence; raw data comes last so a clear removes any letter codes
  initial
  begin
    void'($urandom(32'h75939E92));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    cmd(16'h1000);
    observe();
    for (int i = 0; i < 4; i++)
      cmd({4'h2, 4'(i + 2), 1'($urandom_range(0, 1)), 3'h0,
           4'(i == 3 ? 15 : $urandom_range(0, 9))});
    observe();
    for (int i = 0; i < 3; i++)
    begin
      cmd({12'h200, 4'(i == 0 ? 0 : i == 1 ? $urandom_range(1, 14) : 15)});
      observe();
    end
    cmd(16'h2300, 8, 8'h07); // Shifting under load must not move the target
    observe();
    cmd(16'h2101);
    cmd({8'h22, 8'($urandom)});
    cmd({8'h23, 8'($urandom)});
    observe();
    foreach (seq[i])
    begin
      cmd(seq[i]);
      observe();
    end
    report_and_stop();
  end
  // Watchdog: the sequence needs about 7200 cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule : tb_serial_led_segment_scan_driver
`default_nettype wire
